// ==== rtl/irq_prio_pkg.sv ====
// Constants and carrier types of the interrupt enable and priority bank.
// Assumes one core clock and a plain one-cycle register port.
package irq_prio_pkg;

  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;

  // Register offsets on the register port.
  localparam logic [2:0] OFF_ENABLE_ONE = 3'h0;
  localparam logic [2:0] OFF_ENABLE_TWO = 3'h1;
  localparam logic [2:0] OFF_PRIORITY_ONE = 3'h2;
  localparam logic [2:0] OFF_PRIORITY_TWO = 3'h3;
  localparam logic [2:0] OFF_FLAG_ONE = 3'h4;
  localparam logic [2:0] OFF_FLAG_TWO = 3'h5;
  localparam logic [2:0] OFF_RESET_CAUSE = 3'h6;
  localparam logic [2:0] OFF_CORE_CTRL = 3'h7;

  // Implemented bits of the first and second source banks.
  localparam logic [7:0] BANK_ONE_MASK = 8'h7f;
  localparam logic [7:0] BANK_TWO_MASK = 8'hfa;

  // Reset values.
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [7:0] FLAG_RESET = 8'h00;
  localparam logic [7:0] PRIO_ONE_RESET = 8'h7f;
  localparam logic [7:0] PRIO_TWO_RESET = 8'hfa;
  localparam logic [7:0] RESET_CAUSE_RESET = 8'h5c;

  // Reset-cause register layout.
  localparam int RC_PRIO_LEVELS_BIT = 7;
  localparam int RC_SOFT_BROWNOUT_BIT = 6;
  localparam logic [7:0] RC_WRITE_MASK = 8'hd3;
  localparam logic [7:0] RC_READ_MASK = 8'hdf;

  // Core control register layout.
  localparam int CTRL_PERIPH_GLOBAL_BIT = 0;

  // First bank source positions.
  localparam int SRC_TIMER1_OVF = 0;
  localparam int SRC_TIMER2_MATCH = 1;
  localparam int SRC_CAPCOMP = 2;
  localparam int SRC_SYNC_SERIAL = 3;
  localparam int SRC_SERIAL_TX = 4;
  localparam int SRC_SERIAL_RX = 5;
  localparam int SRC_CONVERTER = 6;
  // Second bank source positions.
  localparam int SRC_TIMER3_OVF = 1;
  localparam int SRC_BUS_COLLISION = 3;
  localparam int SRC_NV_WRITE = 4;
  localparam int SRC_COMPARATOR_TWO = 5;
  localparam int SRC_COMPARATOR_ONE = 6;
  localparam int SRC_OSC_FAIL = 7;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic [7:0] bank_one;
    logic [7:0] bank_two;
  } src_events_t;

endpackage : irq_prio_pkg

// ==== rtl/periph_irq_enable_priority.sv ====
// Peripheral interrupt flags, enables, priorities and routing to the core.
// Assumes source events are one-cycle pulses from logic on the core clock
// and that software uses the one-cycle register port described below.
//
// Decided for this implementation: strobed register access and the register addresses.
module periph_irq_enable_priority (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire irq_prio_pkg::reg_req_t req_in,
  input wire irq_prio_pkg::src_events_t events_in,
  output logic [irq_prio_pkg::DATA_W-1:0] rdata_out,
  output logic irq_high_out,
  output logic irq_low_out,
  output logic priority_levels_enable_out
);
  import irq_prio_pkg::*;

  typedef struct packed {
    logic [7:0] enable_one;
    logic [7:0] enable_two;
    logic [7:0] priority_one;
    logic [7:0] priority_two;
    logic [7:0] flag_one;
    logic [7:0] flag_two;
    logic [7:0] reset_cause;
    logic peripheral_global_enable;
    logic irq_high;
    logic irq_low;
    logic [7:0] rdata;
  } state_t;

  state_t state_r;
  state_t state_nxt;

  logic [7:0] pend_one;
  logic [7:0] pend_two;
  logic levels_on;
  logic any_pend;
  logic any_high;
  logic any_low;
  logic [7:0] read_mux;

  assign levels_on = state_r.reset_cause[RC_PRIO_LEVELS_BIT];

  assign pend_one = state_r.flag_one & state_r.enable_one & BANK_ONE_MASK;
  assign pend_two = state_r.flag_two & state_r.enable_two & BANK_TWO_MASK;
  assign any_pend = |{pend_one, pend_two};
  assign any_high = |{pend_one & state_r.priority_one,
                      pend_two & state_r.priority_two};
  assign any_low = |{pend_one & ~state_r.priority_one,
                     pend_two & ~state_r.priority_two};

  always_comb begin
    case (req_in.addr)
      OFF_ENABLE_ONE: read_mux = state_r.enable_one & BANK_ONE_MASK;
      OFF_ENABLE_TWO: read_mux = state_r.enable_two & BANK_TWO_MASK;
      OFF_PRIORITY_ONE: read_mux = state_r.priority_one & BANK_ONE_MASK;
      OFF_PRIORITY_TWO: read_mux = state_r.priority_two & BANK_TWO_MASK;
      OFF_FLAG_ONE: read_mux = state_r.flag_one & BANK_ONE_MASK;
      OFF_FLAG_TWO: read_mux = state_r.flag_two & BANK_TWO_MASK;
      OFF_RESET_CAUSE: read_mux = state_r.reset_cause & RC_READ_MASK;
      OFF_CORE_CTRL: read_mux = {7'h00, state_r.peripheral_global_enable};
      default: read_mux = 8'h00;
    endcase
  end

  always_comb begin
    state_nxt = state_r;
    // Read data stands only in the cycle after the strobe.
    state_nxt.rdata = req_in.rd ? read_mux : 8'h00;
    if (req_in.wr) begin
      case (req_in.addr)
        OFF_ENABLE_ONE: state_nxt.enable_one = req_in.wdata & BANK_ONE_MASK;
        OFF_ENABLE_TWO: state_nxt.enable_two = req_in.wdata & BANK_TWO_MASK;
        OFF_PRIORITY_ONE: begin
          state_nxt.priority_one = req_in.wdata & BANK_ONE_MASK;
        end
        OFF_PRIORITY_TWO: begin
          state_nxt.priority_two = req_in.wdata & BANK_TWO_MASK;
        end
        OFF_FLAG_ONE: state_nxt.flag_one = req_in.wdata & BANK_ONE_MASK;
        OFF_FLAG_TWO: state_nxt.flag_two = req_in.wdata & BANK_TWO_MASK;
        OFF_RESET_CAUSE: begin
          state_nxt.reset_cause = (state_r.reset_cause & ~RC_WRITE_MASK)
                                | (req_in.wdata & RC_WRITE_MASK);
        end
        OFF_CORE_CTRL: begin
          state_nxt.peripheral_global_enable =
            req_in.wdata[CTRL_PERIPH_GLOBAL_BIT];
        end
        default: state_nxt.rdata = state_nxt.rdata;
      endcase
    end
    // event sets flag
    // A software clear in the same cycle as an event loses to the event.
    state_nxt.flag_one = state_nxt.flag_one
                       | (events_in.bank_one & BANK_ONE_MASK);
    state_nxt.flag_two = state_nxt.flag_two
                       | (events_in.bank_two & BANK_TWO_MASK);
    if (levels_on) begin
      state_nxt.irq_high = any_high;
      state_nxt.irq_low = any_low;
    end else begin
      state_nxt.irq_high = any_pend & state_r.peripheral_global_enable;
      state_nxt.irq_low = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_r.enable_one <= ENABLE_RESET;
      state_r.enable_two <= ENABLE_RESET;
      state_r.priority_one <= PRIO_ONE_RESET;
      state_r.priority_two <= PRIO_TWO_RESET;
      state_r.flag_one <= FLAG_RESET;
      state_r.flag_two <= FLAG_RESET;
      state_r.reset_cause <= RESET_CAUSE_RESET;
      state_r.peripheral_global_enable <= 1'b0;
      state_r.irq_high <= 1'b0;
      state_r.irq_low <= 1'b0;
      state_r.rdata <= 8'h00;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Outputs come straight from the state register; the request lines lag
  // the flags by one cycle, which the core tolerates as it samples them.
  assign rdata_out = state_r.rdata;
  assign irq_high_out = state_r.irq_high;
  assign irq_low_out = state_r.irq_low;
  assign priority_levels_enable_out = levels_on;

  default clocking dc @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_b_in);

  a_compat_global_gate: assert property (
    (!levels_on && !state_r.peripheral_global_enable) |=> !irq_high_out)
    else $error("Request raised without peripheral global enable.");

  a_enable_one_bits: assert property (
    req_in.wr && req_in.addr == OFF_ENABLE_ONE
    |=> state_r.enable_one == ($past(req_in.wdata) & BANK_ONE_MASK))
    else $error("First enable register did not take the write.");

  a_enable_blocks_src: assert property (
    (!levels_on && state_r.peripheral_global_enable
     && (state_r.flag_one & state_r.enable_one) == 8'h00
     && (state_r.flag_two & state_r.enable_two) == 8'h00)
    |=> !irq_high_out)
    else $error("Disabled source raised a request.");

  a_enable_two_zero: assert property (
    (state_r.enable_two & ~BANK_TWO_MASK) == 8'h00)
    else $error("Unimplemented second enable bit set.");

  a_prio_one_zero: assert property (
    req_in.wr && req_in.addr == OFF_PRIORITY_ONE
    |=> !state_r.priority_one[7])
    else $error("First priority bit 7 not zero.");

  a_prio_reset_high: assert property (
    $rose(rst_b_in) |-> state_r.priority_one == PRIO_ONE_RESET
                        && state_r.priority_two == PRIO_TWO_RESET)
    else $error("Priority bits not high after reset.");

  a_prio_two_zero: assert property (
    (state_r.priority_two & ~BANK_TWO_MASK) == 8'h00)
    else $error("Unimplemented second priority bit set.");

  a_prio_ignored_off: assert property (
    !levels_on |=> !irq_low_out)
    else $error("Low line driven with priority levels off.");

  a_levels_bit_write: assert property (
    req_in.wr && req_in.addr == OFF_RESET_CAUSE
    |=> priority_levels_enable_out == $past(req_in.wdata[RC_PRIO_LEVELS_BIT]))
    else $error("Priority-level enable did not take the write.");

  a_event_sets_flag: assert property (
    events_in.bank_one[0] |=> state_r.flag_one[0] ##1 1'b1)
    else $error("Event did not set its flag.");

  a_low_route: assert property (
    levels_on && |(state_r.flag_two & state_r.enable_two
                   & ~state_r.priority_two & BANK_TWO_MASK)
    |=> irq_low_out)
    else $error("Low-priority source not routed to low line.");

  a_enable_one_read: assert property (
    req_in.rd && req_in.addr == OFF_ENABLE_ONE
    |=> rdata_out == $past(state_r.enable_one) && !rdata_out[7])
    else $error("First enable register read back wrongly.");

  a_enable_reset_low: assert property (
    $rose(rst_b_in) |-> state_r.enable_one == ENABLE_RESET
                        && state_r.enable_two == ENABLE_RESET)
    else $error("Enable bits not low after reset.");

  a_idle_lines_quiet: assert property (
    levels_on && !any_pend |=> !irq_high_out && !irq_low_out)
    else $error("Request line raised with nothing pending.");

  a_enable_two_write: assert property (
    req_in.wr && req_in.addr == OFF_ENABLE_TWO
    |=> state_r.enable_two == ($past(req_in.wdata) & BANK_TWO_MASK))
    else $error("Second enable register did not take the write.");

  a_prio_one_write: assert property (
    req_in.wr && req_in.addr == OFF_PRIORITY_ONE
    |=> state_r.priority_one == ($past(req_in.wdata) & BANK_ONE_MASK))
    else $error("First priority register did not take the write.");

  a_prio_two_write: assert property (
    req_in.wr && req_in.addr == OFF_PRIORITY_TWO
    |=> state_r.priority_two == ($past(req_in.wdata) & BANK_TWO_MASK))
    else $error("Second priority register did not take the write.");

  a_prio_two_read: assert property (
    req_in.rd && req_in.addr == OFF_PRIORITY_TWO
    |=> (rdata_out & ~BANK_TWO_MASK) == 8'h00)
    else $error("Unimplemented second priority bit read as one.");

  a_prio_steers_low: assert property (
    levels_on && |(pend_one & ~state_r.priority_one) |=> irq_low_out)
    else $error("Low-priority first-bank source not on low line.");

  a_global_ignored_on: assert property (
    levels_on && !state_r.peripheral_global_enable && any_high
    |=> irq_high_out)
    else $error("Global enable gated a request with levels on.");

  a_levels_reset_off: assert property (
    $rose(rst_b_in) |-> !priority_levels_enable_out)
    else $error("Priority levels enabled after reset.");

  a_cause_ro_bits: assert property (
    req_in.wr && req_in.addr == OFF_RESET_CAUSE
    |=> (state_r.reset_cause & ~RC_WRITE_MASK)
        == ($past(state_r.reset_cause) & ~RC_WRITE_MASK))
    else $error("Read-only reset-cause bits changed on a write.");

  a_flag_two_write: assert property (
    req_in.wr && req_in.addr == OFF_FLAG_TWO && events_in.bank_two == 8'h00
    |=> state_r.flag_two == ($past(req_in.wdata) & BANK_TWO_MASK))
    else $error("Second flag register did not take the write.");

  a_flag_one_holds: assert property (
    !(req_in.wr && req_in.addr == OFF_FLAG_ONE)
    |=> (state_r.flag_one & $past(state_r.flag_one))
        == $past(state_r.flag_one))
    else $error("First-bank flag dropped without a write.");

  a_timer3_sets_flag: assert property (
    events_in.bank_two[SRC_TIMER3_OVF] |=> state_r.flag_two[SRC_TIMER3_OVF])
    else $error("Second-bank event did not set its flag.");

  a_compat_route: assert property (
    !levels_on && state_r.peripheral_global_enable && any_pend
    |=> irq_high_out)
    else $error("Enabled source not raised with levels off.");

  a_high_route: assert property (
    levels_on && |(pend_one & state_r.priority_one) |=> irq_high_out)
    else $error("High-priority source not routed to high line.");

  for (genvar b = SRC_TIMER1_OVF; b <= SRC_CONVERTER; b++) begin : g_flag_one
    a_flag_one_set: assert property (
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      events_in.bank_one[b] |=> state_r.flag_one[b])
      else $error("First-bank event did not set its flag.");
  end : g_flag_one

  c_high_request: cover property (levels_on ##1 irq_high_out);
  c_low_then_high: cover property (irq_low_out ##1 irq_high_out);
  c_low_request: cover property (irq_low_out ##1 !irq_low_out);
  c_compat_request: cover property (!levels_on ##1 irq_high_out);
  c_clear_vs_event: cover property (
    req_in.wr && req_in.addr == OFF_FLAG_ONE && |events_in.bank_one);

endmodule : periph_irq_enable_priority

// ==== testbench/src_model.sv ====
// Model of the peripheral flag sources that feed the interrupt bank.
// Assumes the bench asks for events on the core clock, one cycle at a time.
module src_model (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire irq_prio_pkg::src_events_t trig_in,
  output irq_prio_pkg::src_events_t events_out
);
  timeunit 1ns;
  timeprecision 1ns;
  import irq_prio_pkg::*;

  // Registering the request keeps each event a clean one-cycle pulse.
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      events_out <= '0;
    end else begin
      events_out <= trig_in;
    end
  end
endmodule : src_model

// ==== testbench/tb.sv ====
// Self-checking bench of the peripheral interrupt enable and priority bank.
// Assumes the one-cycle register port and the event model beside it.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import irq_prio_pkg::*;

  logic clk_sys_in = 1'b0;
  logic rst_b_in = 1'b0;
  reg_req_t req = '0;
  src_events_t trig = '0;
  src_events_t events;
  logic [7:0] rdata;
  logic irq_high;
  logic irq_low;
  logic prio_lvl;
  int mismatches = 0;
  int checks = 0;
  int cycles = 0;

  always #5 clk_sys_in = ~clk_sys_in;

  periph_irq_enable_priority i_periph_irq_enable_priority (
    .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .req_in(req),
    .events_in(events), .rdata_out(rdata), .irq_high_out(irq_high),
    .irq_low_out(irq_low), .priority_levels_enable_out(prio_lvl));

  src_model i_src_model (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
    .trig_in(trig), .events_out(events));

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test

  // The whole run needs well under a thousand cycles.
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      stop_test();
    end
  end

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk1(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk1

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    req.wr <= 1'b1;
    req.addr <= a;
    req.wdata <= d;
    @(posedge clk_sys_in);
    req.wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe.
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk_sys_in);
    req.rd <= 1'b1;
    req.addr <= a;
    @(posedge clk_sys_in);
    req.rd <= 1'b0;
    #1;
    chk8(rdata, exp);
  endtask : rd_chk

  task automatic fire(input logic [7:0] b1, input logic [7:0] b2);
    @(posedge clk_sys_in);
    trig <= '{bank_one: b1, bank_two: b2};
    @(posedge clk_sys_in);
    trig <= '0;
  endtask : fire

  // The event and the clearing write reach the bank at the same edge.
  task automatic clash(input logic [7:0] b1);
    @(posedge clk_sys_in);
    trig <= '{bank_one: b1, bank_two: 8'h00};
    @(posedge clk_sys_in);
    trig <= '0;
    req.wr <= 1'b1;
    req.addr <= OFF_FLAG_ONE;
    req.wdata <= 8'h00;
    @(posedge clk_sys_in);
    req.wr <= 1'b0;
  endtask : clash

  // Event to line takes two cycles, so three edges cover any cause.
  task automatic lines(input logic h, input logic l);
    repeat (3) @(posedge clk_sys_in);
    #1;
    chk1(irq_high, h);
    chk1(irq_low, l);
  endtask : lines

  initial begin
    repeat (20) @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    rd_chk(OFF_ENABLE_ONE, 8'h00);
    rd_chk(OFF_ENABLE_TWO, 8'h00);
    rd_chk(OFF_PRIORITY_ONE, 8'h7f);
    rd_chk(OFF_PRIORITY_TWO, 8'hfa);
    rd_chk(OFF_RESET_CAUSE, 8'h5c);
    chk1(prio_lvl, 1'b0);
    $display("test reset_values done");
    for (int i = 0; i < 4; i++) begin
      wr(3'(i), 8'hff);
      rd_chk(3'(i), (i % 2 == 1) ? 8'hfa : 8'h7f);
    end
    wr(OFF_ENABLE_ONE, 8'h00);
    wr(OFF_ENABLE_TWO, 8'h00);
    $display("test layout done");
    fire(8'hff, 8'hff);
    lines(1'b0, 1'b0);
    rd_chk(OFF_FLAG_ONE, 8'h7f);
    rd_chk(OFF_FLAG_TWO, 8'hfa);
    $display("test polling done");
    wr(OFF_ENABLE_ONE, 8'h01);
    lines(1'b0, 1'b0);
    wr(OFF_CORE_CTRL, 8'h01);
    lines(1'b1, 1'b0);
    wr(OFF_ENABLE_ONE, 8'h00);
    wr(OFF_ENABLE_TWO, 8'h02);
    wr(OFF_PRIORITY_TWO, 8'h00);
    lines(1'b1, 1'b0);
    $display("test single_level done");
    wr(OFF_RESET_CAUSE, 8'h80);
    lines(1'b0, 1'b1);
    chk1(prio_lvl, 1'b1);
    wr(OFF_CORE_CTRL, 8'h00);
    wr(OFF_PRIORITY_TWO, 8'h02);
    lines(1'b1, 1'b0);
    wr(OFF_FLAG_TWO, 8'h00);
    lines(1'b0, 1'b0);
    $display("test two_level done");
    clash(8'h04);
    rd_chk(OFF_FLAG_ONE, 8'h04);
    wr(OFF_ENABLE_ONE, 8'h04);
    wr(OFF_PRIORITY_ONE, 8'h00);
    lines(1'b0, 1'b1);
    $display("test clash_and_bank_one done");
    @(posedge clk_sys_in);
    rst_b_in <= 1'b0;
    repeat (20) @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    rd_chk(OFF_ENABLE_ONE, 8'h00);
    rd_chk(OFF_PRIORITY_ONE, 8'h7f);
    rd_chk(OFF_FLAG_ONE, 8'h00);
    lines(1'b0, 1'b0);
    chk1(prio_lvl, 1'b0);
    $display("test reset_again done");
    stop_test();
  end
endmodule : tb
